/* include/tcc_pkg.sv */
// Package with register map, field layout and decode types of the timer control bank.
package tcc_pkg;

   // -----------------------------------------------------------------
   // Register map.
   // -----------------------------------------------------------------
   localparam logic [7:0] TCC_IDX_CLK = 8'h00;
   localparam logic [7:0] TCC_IDX_WAVE = 8'h01;
   localparam logic [7:0] TCC_IDX_CMP = 8'h02;
   localparam logic [7:0] TCC_IDX_EVT = 8'h03;
   localparam logic [7:0] TCC_IDX_BYTE = 8'h04;
   localparam logic [7:0] TCC_IDX_IRQ = 8'h06;
   localparam logic [7:0] TCC_IDX_STATUS = 8'h10;
   localparam logic [7:0] TCC_RESET_VAL = 8'h00;
   localparam logic [7:0] TCC_MASK_CLK = 8'h0F;
   localparam logic [7:0] TCC_MASK_WAVE = 8'hF7;
   localparam logic [7:0] TCC_MASK_CMP = 8'h0F;
   localparam logic [7:0] TCC_MASK_EVT = 8'hFF;
   localparam logic [7:0] TCC_MASK_BYTE = 8'h03;
   localparam logic [7:0] TCC_MASK_IRQ = 8'h0F;

   // -----------------------------------------------------------------
   // Field positions.
   // -----------------------------------------------------------------
   localparam int TCC_CHEN_LSB = 4;
   localparam int TCC_EVENT_DELAY_BIT = 4;
   localparam int TCC_EVENT_ACTION_SEL_LSB = 5;
   localparam int TCC_ERRLVL_LSB = 2;

   // -----------------------------------------------------------------
   // Codes.
   // -----------------------------------------------------------------
   localparam logic [3:0] TCC_CLK_OFF = 4'h0;
   localparam logic [3:0] TCC_CLK_DIV1 = 4'h1;
   localparam logic [2:0] TCC_WG_NORMAL = 3'h0;
   localparam logic [2:0] TCC_WG_FREQ = 3'h1;
   localparam logic [2:0] TCC_WG_ONE_SLOPE = 3'h3;
   localparam logic [2:0] TCC_WG_TWO_TOP = 3'h5;
   localparam logic [2:0] TCC_WG_TWO_BOTH = 3'h6;
   localparam logic [2:0] TCC_WG_TWO_BOTTOM = 3'h7;
   localparam logic [2:0] TCC_EV_NONE = 3'h0;
   localparam logic [2:0] TCC_EV_CAPT = 3'h1;
   localparam logic [2:0] TCC_EV_FREQ = 3'h5;
   localparam logic [2:0] TCC_EV_PW = 3'h6;
   localparam logic [2:0] TCC_EV_RSVD = 3'h7;
   localparam logic [1:0] TCC_BM_NORMAL = 2'h0;
   localparam logic [1:0] TCC_BM_UPPER_CLR = 2'h1;
   localparam logic [1:0] TCC_BM_SPLIT = 2'h2;
   localparam logic [9:0] TCC_DIV1024_MAX = 10'h3FF;

   typedef enum logic [1:0] {
      TCC_LVL_OFF,
      TCC_LVL_LOW,
      TCC_LVL_MED,
      TCC_LVL_HIGH
   } tcc_level_t;

   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] dat;
      logic we;
      logic stb;
      logic cyc;
      logic sel;
   } tcc_wb_req_t;

   typedef struct packed {
      logic [2:0] waveform_mode_sel;
      logic [2:0] event_action_sel;
      logic [1:0] byte_mode_sel;
   } tcc_mode_t;

   // Maps the event channel used by capture channel ch for base channel n.
   function automatic logic [2:0] tcc_chan_map(input logic [2:0] n, input logic [1:0] ch);
      tcc_chan_map = n + {1'b0, ch};
   endfunction : tcc_chan_map

   // True for the three capture actions.
   function automatic logic tcc_is_capture(input logic [2:0] act);
      tcc_is_capture = (act == TCC_EV_CAPT) || (act == TCC_EV_FREQ) || (act == TCC_EV_PW);
   endfunction : tcc_is_capture

endpackage : tcc_pkg

/* src/tcc_ctrl.sv */
// Control register bank of the 16-bit timer/counter with its decode logic.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcc_ctrl
   import tcc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Event channels and counter state.
   input wire logic [7:0] event_ch_i,
   input wire logic [3:0] wave_result_i,
   input wire logic [3:0] port_out_i,
   input wire logic top_i,
   input wire logic bottom_i,
   // Decoded controls.
   output logic count_tick_o,
   output logic [3:0] pin_out_o,
   output logic [3:0] capture_event_o,
   output logic [3:0] capture_en_o,
   output logic action_event_o,
   output tcc_mode_t mode_o,
   output logic update_o,
   output logic overflow_event_o,
   output logic capture_mode_o,
   output logic upper_byte_clr_o,
   output logic split_mode_o,
   output tcc_level_t error_irq_level_o,
   output tcc_level_t overflow_irq_level_o
);

   // ------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------
   logic [7:0] clock_source_ctrl;
   logic [7:0] waveform_channel_ctrl;
   logic [7:0] compare_output_ctrl;
   logic [7:0] event_ctrl;
   logic [7:0] byte_mode_ctrl;
   logic [7:0] irq_level_ctrl_a;
   logic [9:0] prescale;
   logic [7:0] event_dly;
   logic [7:0] wave_out;

   tcc_wb_req_t req;
   assign req = '{adr: adr_i, dat: dat_i[7:0], we: we_i, stb: stb_i, cyc: cyc_i, sel: sel_i[0]};

   // ------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------
   wire logic bus_hit = req.cyc && req.stb && !ack_o;
   wire logic [7:0] reg_idx = {2'b00, req.adr[7:2]};
   wire logic wr_en = bus_hit && req.we && req.sel;
   wire logic wr_clk = wr_en && (reg_idx == TCC_IDX_CLK);
   wire logic wr_wave = wr_en && (reg_idx == TCC_IDX_WAVE);
   wire logic wr_cmp = wr_en && (reg_idx == TCC_IDX_CMP);
   wire logic wr_evt = wr_en && (reg_idx == TCC_IDX_EVT);
   wire logic wr_byte = wr_en && (reg_idx == TCC_IDX_BYTE);
   wire logic wr_irq = wr_en && (reg_idx == TCC_IDX_IRQ);

   // ------------------------------------------------------------
   // Field decode.
   // ------------------------------------------------------------
   wire logic [3:0] clock_source_sel = clock_source_ctrl[3:0];
   wire logic [2:0] waveform_mode_sel = waveform_channel_ctrl[2:0];
   wire logic [3:0] channel_enable = waveform_channel_ctrl[7:TCC_CHEN_LSB];
   wire logic [3:0] forced_output_value = compare_output_ctrl[3:0];
   wire logic [2:0] event_action_sel = event_ctrl[7:TCC_EVENT_ACTION_SEL_LSB];
   wire logic event_delay = event_ctrl[TCC_EVENT_DELAY_BIT];
   wire logic [3:0] event_source_sel = event_ctrl[3:0];
   wire logic [1:0] byte_mode_sel = byte_mode_ctrl[1:0];
   wire logic stopped = (clock_source_sel == TCC_CLK_OFF);
   wire logic is_capture = tcc_is_capture(event_action_sel);
   wire logic action_on = (event_action_sel != TCC_EV_NONE) &&
      (event_action_sel != TCC_EV_RSVD);
   wire logic source_on = event_source_sel[3];
   wire logic wave_mode = (waveform_mode_sel == TCC_WG_FREQ) ||
      (waveform_mode_sel == TCC_WG_ONE_SLOPE) || (waveform_mode_sel[2] && waveform_mode_sel[0]) ||
      (waveform_mode_sel == TCC_WG_TWO_BOTH);
   wire logic [7:0] ev_sel = event_delay ? event_dly : event_ch_i;

   // ------------------------------------------------------------
   // Clock source selection.
   // ------------------------------------------------------------
   logic tick;
   always_comb begin
      case (clock_source_sel)
         4'h0: tick = 1'b0;
         4'h1: tick = 1'b1;
         4'h2: tick = (prescale[0] == 1'b1);
         4'h3: tick = (prescale[1:0] == 2'h3);
         4'h4: tick = (prescale[2:0] == 3'h7);
         4'h5: tick = (prescale[5:0] == 6'h3F);
         4'h6: tick = (prescale[7:0] == 8'hFF);
         4'h7: tick = (prescale == TCC_DIV1024_MAX);
         default: tick = event_ch_i[clock_source_sel[2:0]];
      endcase
   end
   assign count_tick_o = tick;

   // ------------------------------------------------------------
   // Event routing.
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         capture_event_o[i] = is_capture && source_on && channel_enable[i] &&
            ev_sel[tcc_chan_map(event_source_sel[2:0], 2'(i))];
      end
   end
   assign action_event_o = action_on && source_on && ev_sel[event_source_sel[2:0]];
   assign capture_en_o = is_capture ? channel_enable : 4'h0;
   assign capture_mode_o = is_capture;

   // ------------------------------------------------------------
   // Waveform mode decode.
   // ------------------------------------------------------------
   always_comb begin
      case (waveform_mode_sel)
         TCC_WG_NORMAL, TCC_WG_FREQ: begin
            update_o = top_i;
            overflow_event_o = top_i;
         end
         TCC_WG_ONE_SLOPE, TCC_WG_TWO_BOTTOM: begin
            update_o = bottom_i;
            overflow_event_o = bottom_i;
         end
         TCC_WG_TWO_TOP: begin
            update_o = bottom_i;
            overflow_event_o = top_i;
         end
         TCC_WG_TWO_BOTH: begin
            update_o = bottom_i;
            overflow_event_o = top_i || bottom_i;
         end
         default: begin
            update_o = 1'b0;
            overflow_event_o = 1'b0;
         end
      endcase
   end
   assign mode_o = '{waveform_mode_sel: waveform_mode_sel, event_action_sel: event_action_sel,
                     byte_mode_sel: byte_mode_sel};
   assign upper_byte_clr_o = (byte_mode_sel == TCC_BM_UPPER_CLR);
   assign split_mode_o = (byte_mode_sel == TCC_BM_SPLIT);
   assign error_irq_level_o = tcc_level_t'(irq_level_ctrl_a[3:TCC_ERRLVL_LSB]);
   assign overflow_irq_level_o = tcc_level_t'(irq_level_ctrl_a[1:0]);

   // ------------------------------------------------------------
   // Pin override.
   // ------------------------------------------------------------
   wire logic [3:0] wave_level = stopped ? forced_output_value : wave_result_i;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_out_o[i] = (wave_mode && !action_on && channel_enable[i]) ?
            wave_out[i] : port_out_i[i];
      end
   end

   // ------------------------------------------------------------
   // Read mux.
   // ------------------------------------------------------------
   logic [7:0] rd_val;
   always_comb begin
      case (reg_idx)
         TCC_IDX_CLK: rd_val = clock_source_ctrl;
         TCC_IDX_WAVE: rd_val = waveform_channel_ctrl;
         TCC_IDX_CMP: rd_val = compare_output_ctrl;
         TCC_IDX_EVT: rd_val = event_ctrl;
         TCC_IDX_BYTE: rd_val = byte_mode_ctrl;
         TCC_IDX_IRQ: rd_val = irq_level_ctrl_a;
         TCC_IDX_STATUS: rd_val = {4'h0, wave_out[3:0]};
         default: rd_val = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Sequential state.
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_source_ctrl <= TCC_RESET_VAL;
         waveform_channel_ctrl <= TCC_RESET_VAL;
         compare_output_ctrl <= TCC_RESET_VAL;
         event_ctrl <= TCC_RESET_VAL;
         byte_mode_ctrl <= TCC_RESET_VAL;
         irq_level_ctrl_a <= TCC_RESET_VAL;
      end else begin
         if (wr_clk) clock_source_ctrl <= req.dat & TCC_MASK_CLK;
         if (wr_wave) waveform_channel_ctrl <= req.dat & TCC_MASK_WAVE;
         if (wr_cmp) compare_output_ctrl <= req.dat & TCC_MASK_CMP;
         if (wr_evt) event_ctrl <= req.dat & TCC_MASK_EVT;
         if (wr_byte) byte_mode_ctrl <= req.dat & TCC_MASK_BYTE;
         if (wr_irq) irq_level_ctrl_a <= req.dat & TCC_MASK_IRQ;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prescale <= 10'h000;
         event_dly <= 8'h00;
         wave_out <= 8'h00;
      end else begin
         prescale <= stopped ? 10'h000 : prescale + 10'h001;
         event_dly <= event_ch_i;
         wave_out <= {4'h0, wave_level};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_hit;
         dat_o <= bus_hit ? {24'h000000, rd_val} : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------
   a_off_no_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      stopped |-> !count_tick_o) else $error("Tick while stopped.");
   a_div1_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      (clock_source_sel == TCC_CLK_DIV1) |-> count_tick_o) else $error("Undivided clock lost.");
   a_pin_override: assert property (@(posedge clk_i) disable iff (rst_i)
      (wave_mode && !action_on && channel_enable[0]) |-> pin_out_o[0] == wave_out[0])
      else $error("Waveform did not reach pin.");
   a_normal_port: assert property (@(posedge clk_i) disable iff (rst_i)
      (waveform_mode_sel == TCC_WG_NORMAL) |-> pin_out_o == port_out_i)
      else $error("Normal mode drove a pin.");
   a_forced_level: assert property (@(posedge clk_i) disable iff (rst_i)
      (stopped && $stable(compare_output_ctrl)) |=> wave_out[3:0] == $past(forced_output_value))
      else $error("Forced level not applied.");
   a_capture_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !is_capture |-> capture_event_o == 4'h0) else $error("Capture outside capture mode.");
   a_event_delay: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_delay && action_on && source_on && $stable(event_source_sel) &&
       $past(event_ch_i[event_source_sel[2:0]]))
      |-> action_event_o) else $error("Delayed event missing.");
   a_action_none: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_action_sel == TCC_EV_NONE) |-> !action_event_o) else $error("Event without action.");
   a_both_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
      (waveform_mode_sel == TCC_WG_TWO_BOTH && bottom_i) |-> overflow_event_o && update_o)
      else $error("Bottom event missing.");
   a_top_update: assert property (@(posedge clk_i) disable iff (rst_i)
      (waveform_mode_sel == TCC_WG_ONE_SLOPE && top_i && !bottom_i) |-> !update_o)
      else $error("Update at top in one-slope.");
   a_split: assert property (@(posedge clk_i) disable iff (rst_i)
      split_mode_o |-> byte_mode_ctrl[1:0] == TCC_BM_SPLIT) else $error("Split decode wrong.");
   a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("Ack held.");
   a_level_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_level_ctrl_a[1:0] == 2'h0) |-> overflow_irq_level_o == TCC_LVL_OFF)
      else $error("Level zero enabled.");
   a_capture_map: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_capture && source_on && channel_enable[1] && !event_delay) |->
      capture_event_o[1] == event_ch_i[3'(event_source_sel[2:0] + 3'h1)])
      else $error("Capture channel mapping wrong.");
   a_normal_update: assert property (@(posedge clk_i) disable iff (rst_i)
      (waveform_mode_sel == TCC_WG_NORMAL) |-> update_o == top_i && overflow_event_o == top_i)
      else $error("Normal mode update wrong.");
   a_upper_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (byte_mode_sel == TCC_BM_UPPER_CLR) |-> upper_byte_clr_o && !split_mode_o)
      else $error("Upper byte clear missing.");

   c_capture: cover property (@(posedge clk_i) disable iff (rst_i) capture_event_o != 4'h0);
   c_pwm_pin: cover property (@(posedge clk_i) disable iff (rst_i)
      wave_mode && channel_enable != 4'h0 && !stopped);
   c_delay: cover property (@(posedge clk_i) disable iff (rst_i) event_delay && action_event_o);

endmodule : tcc_ctrl
`default_nettype wire

/* verif/tcc_ctrl_tb.sv */
// Self-checking testbench for the timer control register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench import tcc_pkg::*;;
   // -----------------------------------------------------------------
   // Signals.
   // -----------------------------------------------------------------
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, top_i, bottom_i;
   logic [7:0] adr_i, event_ch_i;
   logic [3:0] sel_i, wave_result_i, port_out_i, pin_out_o, capture_event_o, capture_en_o;
   logic [31:0] dat_i, dat_o, rd;
   logic count_tick_o, action_event_o, update_o, overflow_event_o;
   logic capture_mode_o, upper_byte_clr_o, split_mode_o;
   tcc_mode_t mode_o;
   tcc_level_t error_irq_level_o, overflow_irq_level_o;
   int n_errors, checks, cycles;
   logic [7:0] reg_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
   logic [7:0] reg_msk [6] = '{TCC_MASK_CLK, TCC_MASK_WAVE, TCC_MASK_CMP, TCC_MASK_EVT,
                              TCC_MASK_BYTE, TCC_MASK_IRQ};

   tcc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .event_ch_i(event_ch_i), .wave_result_i(wave_result_i), .port_out_i(port_out_i),
      .top_i(top_i), .bottom_i(bottom_i), .count_tick_o(count_tick_o), .pin_out_o(pin_out_o),
      .capture_event_o(capture_event_o), .capture_en_o(capture_en_o),
      .action_event_o(action_event_o), .mode_o(mode_o), .update_o(update_o),
      .overflow_event_o(overflow_event_o), .capture_mode_o(capture_mode_o),
      .upper_byte_clr_o(upper_byte_clr_o), .split_mode_o(split_mode_o),
      .error_irq_level_o(error_irq_level_o), .overflow_irq_level_o(overflow_irq_level_o));

   // -----------------------------------------------------------------
   // Clock, timeout and shared tasks.
   // -----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles > 40000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb

   task wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'b1, d, 4'hF);
   endtask : wr

   task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      wb(a, 1'b0, 8'h00, 4'hF);
      chk(name, exp, rd);
   endtask : rdchk

   task settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : settle

   // -----------------------------------------------------------------
   // Scenarios.
   // -----------------------------------------------------------------
   task t_regs();
      for (int i = 0; i < 6; i++) begin
         rdchk("reset value", reg_adr[i], 32'h0);
         wr(reg_adr[i], reg_msk[i]);
         rdchk("masked readback", reg_adr[i], {24'h0, reg_msk[i]});
         wr(reg_adr[i], 8'h00);
      end
      wr(8'h14, 8'hFF);
      rdchk("unmapped", 8'h14, 32'h0);
      wb(8'h18, 1'b1, 8'h05, 4'hE);
      rdchk("unselected write", 8'h18, 32'h0);
   endtask : t_regs

   task automatic t_clock();
      int div [8] = '{0, 1, 2, 4, 8, 64, 256, 1024};
      int n;
      for (int d = 0; d < 8; d++) begin
         wr(8'h00, 8'(d));
         n = 0;
         repeat (2048) begin
            @(posedge clk_i);
            if (count_tick_o === 1'b1) n++;
         end
         chk("tick count", (d == 0) ? 0 : 2048 / div[d], n);
      end
      wr(8'h00, 8'h0B);
      @(posedge clk_i);
      event_ch_i <= 8'h08;
      #1 chk("event tick high", 1, count_tick_o);
      @(posedge clk_i);
      event_ch_i <= 8'hF7;
      #1 chk("event tick low", 0, count_tick_o);
   endtask : t_clock

   task automatic t_wave();
      logic [7:0] upd_top = 8'h03, ovf_top = 8'h63, upd_bot = 8'hE8, ovf_bot = 8'hC8;
      wr(8'h00, 8'h01);
      for (int m = 0; m < 8; m++) begin
         wr(8'h04, {5'b01010, 3'(m)});
         settle(2);
         chk("wave mode", m, mode_o.waveform_mode_sel);
         chk("pin out", (m == 0 || m == 2 || m == 4) ? 4'b1100 : 4'b1001, pin_out_o);
         @(posedge clk_i);
         top_i <= 1'b1;
         #1 chk("update at top", upd_top[m], update_o);
         chk("overflow at top", ovf_top[m], overflow_event_o);
         @(posedge clk_i);
         top_i <= 1'b0;
         bottom_i <= 1'b1;
         #1 chk("update at bottom", upd_bot[m], update_o);
         chk("overflow at bottom", ovf_bot[m], overflow_event_o);
         @(posedge clk_i);
         bottom_i <= 1'b0;
      end
      wr(8'h04, 8'h51);
      wr(8'h0C, 8'h20);
      settle(2);
      chk("pin in capture", 4'b1100, pin_out_o);
      chk("capture enables", 4'b0101, capture_en_o);
      wr(8'h0C, 8'h00);
   endtask : t_wave

   task t_forced();
      wr(8'h04, 8'hF1);
      wr(8'h00, 8'h00);
      wr(8'h08, 8'h0A);
      settle(2);
      chk("forced pin", 4'hA, pin_out_o);
      rdchk("forced status", 8'h40, 32'h0A);
      wr(8'h08, 8'h05);
      settle(2);
      chk("forced pin", 4'h5, pin_out_o);
   endtask : t_forced

   task t_events();
      wr(8'h04, 8'hF0);
      wr(8'h0C, 8'h2E);
      for (int ch = 0; ch < 4; ch++) begin
         @(posedge clk_i);
         event_ch_i <= 8'h01 << ((6 + ch) % 8);
         #1 chk("capture strobe", 4'b0001 << ch, capture_event_o);
         chk("selected event", ch == 0, action_event_o);
      end
      wr(8'h0C, 8'h3E);
      @(posedge clk_i);
      event_ch_i <= 8'h00;
      @(posedge clk_i);
      event_ch_i <= 8'h40;
      #1 chk("delayed event early", 0, action_event_o);
      settle(1);
      chk("delayed event late", 1, action_event_o);
      wr(8'h0C, 8'h0E);
      settle(1);
      chk("event without action", 0, action_event_o);
      wr(8'h0C, 8'h20);
      settle(1);
      chk("event without source", 0, action_event_o);
      for (int a = 0; a < 8; a++) begin
         wr(8'h0C, {3'(a), 5'h0E});
         chk("event action", a, mode_o.event_action_sel);
         chk("capture mode", a == 1 || a == 5 || a == 6, capture_mode_o);
         chk("action gate", a != 0 && a != 7, action_event_o);
      end
   endtask : t_events

   task t_byte_irq();
      for (int b = 0; b < 4; b++) begin
         wr(8'h10, 8'(b));
         chk("upper clear", b == 1, upper_byte_clr_o);
         chk("split", b == 2, split_mode_o);
         chk("byte mode", b, mode_o.byte_mode_sel);
      end
      wr(8'h18, 8'h09);
      chk("error level", 2, error_irq_level_o);
      chk("overflow level", 1, overflow_irq_level_o);
      wr(8'h18, 8'h0E);
      chk("error level", 3, error_irq_level_o);
      chk("overflow level", 2, overflow_irq_level_o);
      wr(8'h18, 8'h00);
      chk("error off", 0, error_irq_level_o);
      chk("overflow off", 0, overflow_irq_level_o);
   endtask : t_byte_irq

   // -----------------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0;
      event_ch_i = 8'h00;
      wave_result_i = 4'b0011;
      port_out_i = 4'b1100;
      top_i = 1'b0;
      bottom_i = 1'b0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_clock();
      t_wave();
      t_forced();
      t_events();
      t_byte_irq();
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
